// [hw/jcr_pkg.sv]
package jcr_pkg;
	localparam int          IR_W          = 6;
	localparam logic [5:0]  IR_PKT_IN     = 6'h05;
	localparam logic [5:0]  IR_RB_OUT     = 6'h04;
	localparam logic [5:0]  IR_BYPASS     = 6'h3F;
	localparam logic [5:0]  IR_CAPTURE    = 6'h01;
	localparam int          WORD_W        = 16;
	localparam int          RB_W          = 32;
	localparam logic [15:0] SYNC_HI       = 16'hAA99;
	localparam logic [15:0] SYNC_LO       = 16'h5566;
	localparam logic [15:0] HDR_RD_STATUS = 16'h2901;
	localparam logic [15:0] WORD_NOOP     = 16'h2000;
	localparam int          RST_CLKS      = 5;
	localparam int          RTI_CLKS      = 1;
	localparam int          NAV_CLKS      = 2;
	localparam int          STATUS_WORDS  = 5;
	localparam int          STATUS_BITS   = STATUS_WORDS * WORD_W;
	localparam int          FIFO_DEPTH    = 16;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          TCK_PERIOD_NS = 80;
	localparam int          TCK_HALF_CYC  = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	typedef enum logic [3:0] {
		T_TLR, T_RTI, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
		T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UPD_IR
	} jcr_tap_type;

	typedef enum logic [3:0] {
		H_IDLE, H_RST, H_RTI, H_SELIR, H_CAPIR, H_IR, H_SELDR, H_CAPDR, H_DR, H_END
	} jcr_hst_type;

	typedef enum logic [1:0] {
		OP_WRITE, OP_READ, OP_STATUS
	} jcr_op_type;
endpackage

// [hw/jcr_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface jcr_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;

	modport dev (
		input  tck,
		input  tms,
		input  tdi,
		output tdo
	);

	modport host (
		output tck,
		output tms,
		output tdi,
		input  tdo
	);
endinterface
`default_nettype wire

// [hw/jcr_host.sv]
// Summary of operation
// - Packet-input words go to packet processor
// - Commands in via input, data out via output
// - Five mode-select highs reach reset first
// - One low, two high, two low reach Shift-IR
// - Six-bit instruction, LSB first, codes 05/04
// - Last instruction bit shifted while leaving Shift-IR
// - Two high, two low reach Shift-DR
// - Data shifts MSB first, mode-select low
// - Final LSB shifted while leaving Shift-DR
// - Five mode-select highs reset after access
// - Readable configuration registers return via port
// - Status read: sync, header, two dummy words
// - Readback instruction then 32 status bits out
// - Sync halves AA99 then 5566 first
// - Header 2901, dummy words are 2000 no-ops
`timescale 1ns/1ns
`default_nettype none
module jcr_host #(
	parameter int HALF = jcr_pkg::TCK_HALF_CYC
) (
	input  wire logic                clock_i,
	input  wire logic                nrst_i,
	jcr_link_if.host                 link,
	input  wire logic                req_valid_i,
	output logic                     req_ready_o,
	input  wire jcr_pkg::jcr_op_type req_op_i,
	input  wire logic [15:0]         req_wdata_i,
	output logic                     rsp_valid_o,
	output logic [31:0]              rsp_data_o
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] status_word(input logic [2:0] idx);
		if (idx == 3'h0)
			status_word = jcr_pkg::SYNC_HI;
		else if (idx == 3'h1)
			status_word = jcr_pkg::SYNC_LO;
		else if (idx == 3'h2)
			status_word = jcr_pkg::HDR_RD_STATUS;
		else
			status_word = jcr_pkg::WORD_NOOP;
	endfunction

	function automatic logic in_sel(input jcr_pkg::jcr_op_type op, input logic ph);
		in_sel = (op == jcr_pkg::OP_WRITE) || (op == jcr_pkg::OP_STATUS && !ph);
	endfunction

	function automatic logic [6:0] dr_len(input jcr_pkg::jcr_op_type op, input logic ph);
		if (op == jcr_pkg::OP_WRITE)
			dr_len = 7'(jcr_pkg::WORD_W);
		else if (op == jcr_pkg::OP_STATUS && !ph)
			dr_len = 7'(jcr_pkg::STATUS_BITS);
		else
			dr_len = 7'(jcr_pkg::RB_W);
	endfunction

	function automatic logic [6:0] seg_len(input jcr_pkg::jcr_hst_type s, input logic [6:0] dl);
		unique case (s)
			jcr_pkg::H_RST, jcr_pkg::H_END:
				seg_len = 7'(jcr_pkg::RST_CLKS);
			jcr_pkg::H_RTI:
				seg_len = 7'(jcr_pkg::RTI_CLKS);
			jcr_pkg::H_SELIR, jcr_pkg::H_CAPIR, jcr_pkg::H_SELDR, jcr_pkg::H_CAPDR:
				seg_len = 7'(jcr_pkg::NAV_CLKS);
			jcr_pkg::H_IR:
				seg_len = 7'(jcr_pkg::IR_W);
			jcr_pkg::H_DR:
				seg_len = dl;
			jcr_pkg::H_IDLE:
				seg_len = 7'h01;
		endcase
	endfunction

	function automatic jcr_pkg::jcr_hst_type next_seg(input jcr_pkg::jcr_hst_type s);
		unique case (s)
			jcr_pkg::H_IDLE:  next_seg = jcr_pkg::H_IDLE;
			jcr_pkg::H_RST:   next_seg = jcr_pkg::H_RTI;
			jcr_pkg::H_RTI:   next_seg = jcr_pkg::H_SELIR;
			jcr_pkg::H_SELIR: next_seg = jcr_pkg::H_CAPIR;
			jcr_pkg::H_CAPIR: next_seg = jcr_pkg::H_IR;
			jcr_pkg::H_IR:    next_seg = jcr_pkg::H_SELDR;
			jcr_pkg::H_SELDR: next_seg = jcr_pkg::H_CAPDR;
			jcr_pkg::H_CAPDR: next_seg = jcr_pkg::H_DR;
			jcr_pkg::H_DR:    next_seg = jcr_pkg::H_END;
			jcr_pkg::H_END:   next_seg = jcr_pkg::H_IDLE;
		endcase
	endfunction

	function automatic logic tms_of(input jcr_pkg::jcr_hst_type s, input logic last);
		unique case (s)
			jcr_pkg::H_RST, jcr_pkg::H_END, jcr_pkg::H_SELIR, jcr_pkg::H_SELDR:
				tms_of = 1'b1;
			jcr_pkg::H_RTI, jcr_pkg::H_CAPIR, jcr_pkg::H_CAPDR, jcr_pkg::H_IDLE:
				tms_of = 1'b0;
			jcr_pkg::H_IR, jcr_pkg::H_DR:
				tms_of = last;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

	jcr_pkg::jcr_hst_type st_ff, nxt_st;
	jcr_pkg::jcr_op_type  op_ff, nxt_op;
	logic [6:0]           cnt_ff, nxt_cnt;
	logic [7:0]           div_ff, nxt_div;
	logic                 tck_ff, nxt_tck;
	logic                 tms_ff, nxt_tms;
	logic                 tdi_ff, nxt_tdi;
	logic                 phase_ff, nxt_phase;
	logic [15:0]          wdata_ff, nxt_wdata;
	logic [31:0]          rd_ff, nxt_rd;
	logic                 rsp_v_ff, nxt_rsp_v;
	logic [31:0]          rsp_d_ff, nxt_rsp_d;
	logic                 tdo_s1_ff;
	logic                 tdo_s2_ff;
	logic                 go;
	logic [6:0]           len_cur;
	logic [6:0]           len_nxt;
	logic [5:0]           code;
	logic [15:0]          word;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st    = st_ff;
		nxt_op    = op_ff;
		nxt_cnt   = cnt_ff;
		nxt_div   = div_ff;
		nxt_tck   = tck_ff;
		nxt_tms   = tms_ff;
		nxt_tdi   = tdi_ff;
		nxt_phase = phase_ff;
		nxt_wdata = wdata_ff;
		nxt_rd    = rd_ff;
		nxt_rsp_v = 1'b0;
		nxt_rsp_d = rsp_d_ff;
		go        = 1'b0;
		len_cur   = seg_len(st_ff, dr_len(op_ff, phase_ff));
		if (st_ff == jcr_pkg::H_IDLE) begin
			nxt_div = 8'h00;
			nxt_tck = 1'b0;
			if (req_valid_i) begin
				nxt_op    = req_op_i;
				nxt_wdata = req_wdata_i;
				nxt_phase = 1'b0;
				nxt_rd    = 32'h0000_0000;
				nxt_st    = jcr_pkg::H_RST;
				nxt_cnt   = 7'h00;
				go        = 1'b1;
			end
		end else if (div_ff == HALF_M1) begin
			nxt_div = 8'h00;
			nxt_tck = ~tck_ff;
			// Sampled at the fall: tdo lags by two sync stages plus the far edge detector
			if (tck_ff && st_ff == jcr_pkg::H_DR && !in_sel(op_ff, phase_ff))
				nxt_rd = {rd_ff[30:0], tdo_s2_ff};
			if (tck_ff && cnt_ff == len_cur - 7'h01) begin
				nxt_cnt = 7'h00;
				nxt_st  = next_seg(st_ff);
				go      = 1'b1;
				if (st_ff == jcr_pkg::H_END) begin
					if (op_ff == jcr_pkg::OP_STATUS && !phase_ff) begin
						nxt_phase = 1'b1;
						nxt_st    = jcr_pkg::H_RST;
					end else begin
						nxt_rsp_v = 1'b1;
						nxt_rsp_d = rd_ff;
					end
				end
			end else if (tck_ff) begin
				nxt_cnt = cnt_ff + 7'h01;
				go      = 1'b1;
			end
		end else begin
			nxt_div = div_ff + 8'h01;
		end
		len_nxt = seg_len(nxt_st, dr_len(nxt_op, nxt_phase));
		code    = in_sel(nxt_op, nxt_phase) ? jcr_pkg::IR_PKT_IN : jcr_pkg::IR_RB_OUT;
		word    = (nxt_op == jcr_pkg::OP_WRITE) ? nxt_wdata : status_word(nxt_cnt[6:4]);
		if (go) begin
			// New bit is set up on the falling edge, ahead of the rise
			nxt_tms = tms_of(nxt_st, nxt_cnt == len_nxt - 7'h01);
			if (nxt_st == jcr_pkg::H_IR)
				nxt_tdi = code[nxt_cnt[2:0]];
			else if (nxt_st == jcr_pkg::H_DR && in_sel(nxt_op, nxt_phase))
				nxt_tdi = word[4'hF - nxt_cnt[3:0]];
			else
				nxt_tdi = 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff     <= jcr_pkg::H_IDLE;
			op_ff     <= jcr_pkg::OP_WRITE;
			cnt_ff    <= 7'h00;
			div_ff    <= 8'h00;
			tck_ff    <= 1'b0;
			tms_ff    <= 1'b1;
			tdi_ff    <= 1'b0;
			phase_ff  <= 1'b0;
			wdata_ff  <= 16'h0000;
			rd_ff     <= 32'h0000_0000;
			rsp_v_ff  <= 1'b0;
			rsp_d_ff  <= 32'h0000_0000;
			tdo_s1_ff <= 1'b0;
			tdo_s2_ff <= 1'b0;
		end else begin
			st_ff     <= nxt_st;
			op_ff     <= nxt_op;
			cnt_ff    <= nxt_cnt;
			div_ff    <= nxt_div;
			tck_ff    <= nxt_tck;
			tms_ff    <= nxt_tms;
			tdi_ff    <= nxt_tdi;
			phase_ff  <= nxt_phase;
			wdata_ff  <= nxt_wdata;
			rd_ff     <= nxt_rd;
			rsp_v_ff  <= nxt_rsp_v;
			rsp_d_ff  <= nxt_rsp_d;
			tdo_s1_ff <= link.tdo;
			tdo_s2_ff <= tdo_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.tck    = tck_ff;
	assign link.tms    = tms_ff;
	assign link.tdi    = tdi_ff;
	assign req_ready_o = (st_ff == jcr_pkg::H_IDLE);
	assign rsp_valid_o = rsp_v_ff;
	assign rsp_data_o  = rsp_d_ff;

endmodule
`default_nettype wire

// [hw/jcr_dev.sv]
`timescale 1ns/1ns
`default_nettype none
module jcr_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	logic [W-1:0] nxt_mem [DEPTH];
	logic [AW:0]  wr_ff, nxt_wr;
	logic [AW:0]  rd_ff, nxt_rd;
	logic         full;
	logic         empty;

	// Depth must be a power of two: pointers wrap by overflow
	assign empty       = (wr_ff == rd_ff);
	assign full        = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem_ff[rd_ff[AW-1:0]];

	always_comb begin
		nxt_mem = mem_ff;
		nxt_wr  = wr_ff;
		nxt_rd  = rd_ff;
		if (in_valid_i && !full) begin
			nxt_mem[wr_ff[AW-1:0]] = in_data_i;
			nxt_wr                 = wr_ff + 1'b1;
		end
		if (out_ready_i && !empty)
			nxt_rd = rd_ff + 1'b1;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= '0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			mem_ff <= nxt_mem;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module jcr_dev #(
	parameter int DEPTH = jcr_pkg::FIFO_DEPTH
) (
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	jcr_link_if.dev          link,
	output logic             pkt_valid_o,
	input  wire logic        pkt_ready_i,
	output logic [15:0]      pkt_data_o,
	input  wire logic [31:0] rb_data_i,
	output logic             rb_load_o,
	output logic             pkt_sel_o,
	output logic             overrun_o,
	output logic             synced_o
);

	function automatic jcr_pkg::jcr_tap_type tap_next(input jcr_pkg::jcr_tap_type s, input logic m);
		unique case (s)
			jcr_pkg::T_TLR:    tap_next = m ? jcr_pkg::T_TLR    : jcr_pkg::T_RTI;
			jcr_pkg::T_RTI:    tap_next = m ? jcr_pkg::T_SEL_DR : jcr_pkg::T_RTI;
			jcr_pkg::T_SEL_DR: tap_next = m ? jcr_pkg::T_SEL_IR : jcr_pkg::T_CAP_DR;
			jcr_pkg::T_CAP_DR: tap_next = m ? jcr_pkg::T_EX1_DR : jcr_pkg::T_SH_DR;
			jcr_pkg::T_SH_DR:  tap_next = m ? jcr_pkg::T_EX1_DR : jcr_pkg::T_SH_DR;
			jcr_pkg::T_EX1_DR: tap_next = m ? jcr_pkg::T_UPD_DR : jcr_pkg::T_PA_DR;
			jcr_pkg::T_PA_DR:  tap_next = m ? jcr_pkg::T_EX2_DR : jcr_pkg::T_PA_DR;
			jcr_pkg::T_EX2_DR: tap_next = m ? jcr_pkg::T_UPD_DR : jcr_pkg::T_SH_DR;
			jcr_pkg::T_UPD_DR: tap_next = m ? jcr_pkg::T_SEL_DR : jcr_pkg::T_RTI;
			jcr_pkg::T_SEL_IR: tap_next = m ? jcr_pkg::T_TLR    : jcr_pkg::T_CAP_IR;
			jcr_pkg::T_CAP_IR: tap_next = m ? jcr_pkg::T_EX1_IR : jcr_pkg::T_SH_IR;
			jcr_pkg::T_SH_IR:  tap_next = m ? jcr_pkg::T_EX1_IR : jcr_pkg::T_SH_IR;
			jcr_pkg::T_EX1_IR: tap_next = m ? jcr_pkg::T_UPD_IR : jcr_pkg::T_PA_IR;
			jcr_pkg::T_PA_IR:  tap_next = m ? jcr_pkg::T_EX2_IR : jcr_pkg::T_PA_IR;
			jcr_pkg::T_EX2_IR: tap_next = m ? jcr_pkg::T_UPD_IR : jcr_pkg::T_SH_IR;
			jcr_pkg::T_UPD_IR: tap_next = m ? jcr_pkg::T_SEL_DR : jcr_pkg::T_RTI;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	jcr_pkg::jcr_tap_type tap_ff, nxt_tap;
	logic [5:0]           ir_sh_ff, nxt_ir_sh;
	logic [5:0]           ir_ff, nxt_ir;
	logic                 byp_ff, nxt_byp;
	logic [15:0]          pi_sh_ff, nxt_pi_sh;
	logic [3:0]           pi_cnt_ff, nxt_pi_cnt;
	logic [31:0]          rb_sh_ff, nxt_rb_sh;
	logic                 tdo_ff, nxt_tdo;
	logic                 push_ff, nxt_push;
	logic [15:0]          push_d_ff, nxt_push_d;
	logic                 ovr_ff, nxt_ovr;
	logic [1:0]           sync_ff, nxt_sync;
	logic                 rbl_ff, nxt_rbl;
	logic [2:0]           tck_s_ff;
	logic [1:0]           tms_s_ff;
	logic [1:0]           tdi_s_ff;
	logic                 rise;
	logic                 fall;
	logic                 sel_pi;
	logic                 sel_rb;
	logic                 fifo_rdy;
	logic [15:0]          word;

	// Third tck stage only feeds the edge detector, never the first stage
	assign rise   = tck_s_ff[1] & ~tck_s_ff[2];
	assign fall   = ~tck_s_ff[1] & tck_s_ff[2];
	assign sel_pi = (ir_ff == jcr_pkg::IR_PKT_IN);
	assign sel_rb = (ir_ff == jcr_pkg::IR_RB_OUT);
	assign word   = {pi_sh_ff[14:0], tdi_s_ff[1]};

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_tap    = tap_ff;
		nxt_ir_sh  = ir_sh_ff;
		nxt_ir     = ir_ff;
		nxt_byp    = byp_ff;
		nxt_pi_sh  = pi_sh_ff;
		nxt_pi_cnt = pi_cnt_ff;
		nxt_rb_sh  = rb_sh_ff;
		nxt_tdo    = tdo_ff;
		nxt_push   = 1'b0;
		nxt_push_d = push_d_ff;
		nxt_rbl    = 1'b0;
		nxt_sync   = sync_ff;
		nxt_ovr    = ovr_ff;
		if (rise) begin
			if (tap_ff == jcr_pkg::T_TLR) begin
				nxt_ir = jcr_pkg::IR_BYPASS;
			end else if (tap_ff == jcr_pkg::T_CAP_IR) begin
				nxt_ir_sh = jcr_pkg::IR_CAPTURE;
			end else if (tap_ff == jcr_pkg::T_SH_IR) begin
				nxt_ir_sh = {tdi_s_ff[1], ir_sh_ff[5:1]};
			end else if (tap_ff == jcr_pkg::T_UPD_IR) begin
				nxt_ir = ir_sh_ff;
			end else if (tap_ff == jcr_pkg::T_CAP_DR) begin
				nxt_pi_cnt = 4'h0;
				nxt_byp    = 1'b0;
				if (sel_rb) begin
					nxt_rb_sh = rb_data_i;
					nxt_rbl   = 1'b1;
				end
			end else if (tap_ff == jcr_pkg::T_SH_DR) begin
				if (sel_pi) begin
					nxt_pi_sh  = word;
					nxt_pi_cnt = pi_cnt_ff + 4'h1;
					if (pi_cnt_ff == 4'hF) begin
						nxt_push   = 1'b1;
						nxt_push_d = word;
					end
				end else if (sel_rb) begin
					nxt_rb_sh = {rb_sh_ff[30:0], 1'b0};
				end else begin
					nxt_byp = tdi_s_ff[1];
				end
			end
			nxt_tap = tap_next(tap_ff, tms_s_ff[1]);
		end
		if (fall) begin
			if (tap_ff == jcr_pkg::T_SH_IR)
				nxt_tdo = ir_sh_ff[0];
			else if (tap_ff == jcr_pkg::T_SH_DR)
				nxt_tdo = sel_pi ? pi_sh_ff[15] : (sel_rb ? rb_sh_ff[31] : byp_ff);
		end
		// Advisory only; a full FIFO cannot stall the test clock
		if (push_ff) begin
			if (sync_ff == 2'h2)
				nxt_sync = 2'h2;
			else if (sync_ff == 2'h1 && push_d_ff == jcr_pkg::SYNC_LO)
				nxt_sync = 2'h2;
			else if (push_d_ff == jcr_pkg::SYNC_HI)
				nxt_sync = 2'h1;
			else
				nxt_sync = 2'h0;
		end
		if (rise && tap_ff == jcr_pkg::T_TLR)
			nxt_ovr = 1'b0;
		if (push_ff && !fifo_rdy)
			nxt_ovr = 1'b1;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tap_ff    <= jcr_pkg::T_TLR;
			ir_sh_ff  <= jcr_pkg::IR_CAPTURE;
			ir_ff     <= jcr_pkg::IR_BYPASS;
			byp_ff    <= 1'b0;
			pi_sh_ff  <= 16'h0000;
			pi_cnt_ff <= 4'h0;
			rb_sh_ff  <= 32'h0000_0000;
			tdo_ff    <= 1'b0;
			push_ff   <= 1'b0;
			push_d_ff <= 16'h0000;
			ovr_ff    <= 1'b0;
			sync_ff   <= 2'h0;
			rbl_ff    <= 1'b0;
			tck_s_ff  <= 3'h0;
			tms_s_ff  <= 2'h3;
			tdi_s_ff  <= 2'h0;
		end else begin
			tap_ff    <= nxt_tap;
			ir_sh_ff  <= nxt_ir_sh;
			ir_ff     <= nxt_ir;
			byp_ff    <= nxt_byp;
			pi_sh_ff  <= nxt_pi_sh;
			pi_cnt_ff <= nxt_pi_cnt;
			rb_sh_ff  <= nxt_rb_sh;
			tdo_ff    <= nxt_tdo;
			push_ff   <= nxt_push;
			push_d_ff <= nxt_push_d;
			ovr_ff    <= nxt_ovr;
			sync_ff   <= nxt_sync;
			rbl_ff    <= nxt_rbl;
			tck_s_ff  <= {tck_s_ff[1:0], link.tck};
			tms_s_ff  <= {tms_s_ff[0], link.tms};
			tdi_s_ff  <= {tdi_s_ff[0], link.tdi};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	jcr_fifo #(
		.W     (jcr_pkg::WORD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (push_ff),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (push_d_ff),
		.out_valid_o (pkt_valid_o),
		.out_ready_i (pkt_ready_i),
		.out_data_o  (pkt_data_o)
	);

	assign link.tdo  = tdo_ff;
	assign rb_load_o = rbl_ff;
	assign pkt_sel_o = sel_pi;
	assign overrun_o = ovr_ff;
	assign synced_o  = (sync_ff == 2'h2);

endmodule
`default_nettype wire

// [tb/jcr_props.sv]
`timescale 1ns/1ns
`default_nettype none
module jcr_props (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo
);
	// Next TAP state per state nibble, for mode-select low and high
	localparam logic [63:0] NX0 = 64'h1BDD_BBA1_4664_4311;
	localparam logic [63:0] NX1 = 64'h2FEF_CC02_8785_5920;
	logic [3:0] st_ff, nxt_st;
	logic [7:0] ones_ff, nxt_ones, bits_ff, nxt_bits, idle_ff, nxt_idle;
	logic [5:0] sh_ff, nxt_sh, ir_ff, nxt_ir;
	logic       tck_ff, rise;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	////////////////////////////////////////////////////////////////////////////////
	// Shadow TAP, stepped on tck rises seen by the system clock
	always_comb begin
		rise     = tck & ~tck_ff;
		nxt_st   = st_ff;
		nxt_ones = ones_ff;
		nxt_bits = bits_ff;
		nxt_sh   = sh_ff;
		nxt_ir   = ir_ff;
		nxt_idle = (tck != tck_ff) ? 8'h00 : idle_ff + {7'h00, idle_ff != 8'hFF};
		if (st_ff == 4'h0)
			nxt_ir = 6'h3F;
		if (st_ff == 4'h3 || st_ff == 4'hA)
			nxt_bits = 8'h00;
		if (rise) begin
			nxt_st   = tms ? NX1[st_ff*4 +: 4] : NX0[st_ff*4 +: 4];
			nxt_ones = tms ? ones_ff + {7'h00, ones_ff != 8'hFF} : 8'h00;
			if ((st_ff == 4'h4 || st_ff == 4'hB) && !tms)
				nxt_bits = bits_ff + 8'h01;
			if (st_ff == 4'hB)
				nxt_sh = {tdi, sh_ff[5:1]};
			// Simplified: code taken on leaving Shift-IR, not at update
			if (st_ff == 4'hB && tms)
				nxt_ir = {tdi, sh_ff[5:1]};
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff   <= 4'h0;
			ones_ff <= 8'h00;
			bits_ff <= 8'h00;
			idle_ff <= 8'h00;
			sh_ff   <= 6'h00;
			ir_ff   <= 6'h3F;
			tck_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			ones_ff <= nxt_ones;
			bits_ff <= nxt_bits;
			idle_ff <= nxt_idle;
			sh_ff   <= nxt_sh;
			ir_ff   <= nxt_ir;
			tck_ff  <= tck;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_reset_first: assert property (rise && st_ff == 4'h0 && !tms |-> ones_ff >= 8'h05)
		else $error("left reset before five high clocks");
	a_rti_single: assert property (rise && st_ff == 4'h1 |-> tms)
		else $error("stayed in run-test idle");
	a_ir_six_bits: assert property (rise && st_ff == 4'hB && tms |-> bits_ff == 8'h05)
		else $error("instruction length not six");
	a_ir_code_legal: assert property (rise && st_ff == 4'hB && tms |-> {tdi, sh_ff[5:1]} inside {6'h05, 6'h04})
		else $error("unexpected instruction code");
	a_ir_exit_nav: assert property (rise && st_ff == 4'hF |-> tms)
		else $error("update-ir not followed by select-dr");
	a_dr_write_len: assert property (
		rise && st_ff == 4'h4 && tms && ir_ff == 6'h05 |-> bits_ff inside {8'h0F, 8'h4F})
		else $error("packet scan length wrong");
	a_dr_read_len: assert property (rise && st_ff == 4'h4 && tms && ir_ff == 6'h04 |-> bits_ff == 8'h1F)
		else $error("readback scan length not 32");
	a_idle_in_reset: assert property (idle_ff == 8'h14 |-> st_ff == 4'h0)
		else $error("link idles outside reset");
	a_link_change_low: assert property ($changed(tms) || $changed(tdi) |-> !tck)
		else $error("mode-select or data moved while clock high");
	a_tdo_change_low: assert property ($changed(tdo) |-> !tck)
		else $error("return data moved while clock high");

	c_status_scan: cover property (rise && st_ff == 4'h4 && tms && bits_ff == 8'h4F);
	c_read_scan: cover property (rise && st_ff == 4'h4 && tms && ir_ff == 6'h04);
	c_idle_reset: cover property (idle_ff == 8'h14);
endmodule
`default_nettype wire

// [tb/tb_jtag_config_register_access.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_jtag_config_register_access;
	logic                clock_i;
	logic                nrst_i;
	logic                req_valid, req_ready, rsp_valid;
	jcr_pkg::jcr_op_type req_op;
	logic [15:0]         req_wdata, pkt_data, pkt2_data;
	logic [31:0]         rsp_data, rb_data;
	logic                pkt_valid, pkt_ready, rb_load, pkt_sel, overrun, synced;
	logic                pkt2_valid, pkt2_ready, synced2;
	int                  error_cnt, n_compared;
	int                  ovr_n = 0;
	int                  rbl_n = 0;
	int                  sel_n = 0;
	logic [1:0]          wq[$];

	jcr_link_if link ();
	jcr_link_if link2 ();
	jcr_host jcr_host_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link), .req_valid_i(req_valid),
		.req_ready_o(req_ready), .req_op_i(req_op), .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid),
		.rsp_data_o(rsp_data));
	jcr_dev jcr_dev_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link), .pkt_valid_o(pkt_valid),
		.pkt_ready_i(pkt_ready), .pkt_data_o(pkt_data), .rb_data_i(rb_data), .rb_load_o(rb_load),
		.pkt_sel_o(pkt_sel), .overrun_o(overrun), .synced_o(synced));
	// Second device on a link driven by the bench, for host-side faults
	jcr_dev jcr_dev_inst2 (.clock_i(clock_i), .nrst_i(nrst_i), .link(link2), .pkt_valid_o(pkt2_valid),
		.pkt_ready_i(pkt2_ready), .pkt_data_o(pkt2_data), .rb_data_i(32'h0000_0000), .rb_load_o(),
		.pkt_sel_o(), .overrun_o(), .synced_o(synced2));
	jcr_props jcr_props_inst (.clock_i(clock_i), .nrst_i(nrst_i), .tck(link.tck), .tms(link.tms),
		.tdi(link.tdi), .tdo(link.tdo));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 1'b0;
		forever #(jcr_pkg::CLK_PERIOD_NS / 2) clock_i = ~clock_i;
	end

	always @(posedge link.tck)
		wq.push_back({link.tms, link.tdi});

	// Flags clear on TAP reset or pulse for one cycle (rb_load), so count the cycles they stood
	always @(posedge clock_i) begin
		ovr_n += overrun;
		rbl_n += rb_load;
		sel_n += pkt_sel;
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic etms(int k, int n);
		return k < 5 || k == 6 || k == 7 || (k > 14 && k < 18) || k >= 19 + n;
	endfunction

	function automatic logic etdi(int k, int n, logic [5:0] ir, logic [79:0] d);
		if (k >= 10 && k < 16)
			return ir[k-10];
		if (k >= 20 && k < 20 + n)
			return d[n+19-k];
		return 1'b0;
	endfunction

	task automatic access(jcr_pkg::jcr_op_type op, logic [15:0] w);
		int t;
		req_op    <= op;
		req_wdata <= w;
		req_valid <= 1'b1;
		@(posedge clock_i);
		for (t = 0; t < 10 && req_ready !== 1'b1; t++)
			@(posedge clock_i);
		req_valid <= 1'b0;
		if (t == 10) begin
			error_cnt++;
			$display("CHECK FAILED req_ready expected 1 seen 0");
			summarize();
		end
		for (t = 0; t < 4000 && rsp_valid !== 1'b1; t++)
			@(posedge clock_i);
		if (t == 4000) begin
			error_cnt++;
			$display("CHECK FAILED rsp_valid expected 1 seen 0");
			summarize();
		end
	endtask

	task automatic drain(logic two, logic [15:0] exp);
		chk("pkt_valid", {31'h0, two ? pkt2_valid : pkt_valid}, 32'h1);
		chk("pkt_data", {16'h0, two ? pkt2_data : pkt_data}, {16'h0, exp});
		if (two)
			pkt2_ready <= 1'b1;
		else
			pkt_ready <= 1'b1;
		@(posedge clock_i);
		pkt_ready  <= 1'b0;
		pkt2_ready <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic chk_scan(logic [5:0] ir, int n, logic [79:0] d, int base);
		int k;
		int bad;
		bad = 0;
		for (k = 0; k < 25 + n && base + k < wq.size(); k++)
			if (wq[base+k][1] !== etms(k, n) || ((k >= 10 && k < 16) || (k >= 20 && k < 20 + n && ir == 6'h05))
				&& wq[base+k][0] !== etdi(k, n, ir, d))
				bad++;
		chk("scan_bits", 32'(bad), 32'h0);
	endtask

	// Bench acting as host on the second link; tck stops low after the scan
	task automatic bb_scan(logic [5:0] ir, int n, logic [79:0] d);
		int k;
		for (k = 0; k < 25 + n; k++) begin
			link2.tck <= 1'b0;
			link2.tms <= etms(k, n);
			link2.tdi <= etdi(k, n, ir, d);
			repeat (5) @(posedge clock_i);
			link2.tck <= 1'b1;
			repeat (5) @(posedge clock_i);
		end
		link2.tck <= 1'b0;
		repeat (10) @(posedge clock_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i, o0, s0, r0;
		logic [15:0] sw [5];
		nrst_i     = 1'b0;
		req_valid  = 1'b0;
		req_op     = jcr_pkg::OP_WRITE;
		req_wdata  = 16'h0000;
		pkt_ready  = 1'b0;
		pkt2_ready = 1'b0;
		rb_data    = 32'h0000_0000;
		link2.tck  = 1'b0;
		link2.tms  = 1'b1;
		link2.tdi  = 1'b0;
		error_cnt  = 0;
		n_compared = 0;
		repeat (3) @(posedge clock_i);
		nrst_i <= 1'b1;

		s0 = sel_n;
		access(jcr_pkg::OP_WRITE, 16'hA5C3);
		chk("scan_len", 32'(wq.size()), 32'(25 + 16));
		chk_scan(6'h05, 16, {64'h0, 16'hA5C3}, 0);
		chk("wr_rsp", rsp_data, 32'h0000_0000);
		chk("sel_seen", {31'h0, sel_n > s0}, 32'h1);
		chk("sel_after", {31'h0, pkt_sel}, 32'h0);
		drain(1'b0, 16'hA5C3);
		$display("test single write done");

		wq.delete();
		rb_data <= 32'h1234_5678;
		r0 = rbl_n;
		access(jcr_pkg::OP_STATUS, 16'h0000);
		chk("scan_len", 32'(wq.size()), 32'(25 + 80 + 25 + 32));
		chk_scan(6'h05, 80, {16'hAA99, 16'h5566, 16'h2901, 16'h2000, 16'h2000}, 0);
		chk_scan(6'h04, 32, 80'h0, wq.size() - 57);
		chk("status", rsp_data, 32'h1234_5678);
		chk("rb_load", 32'(rbl_n - r0), 32'h1);
		chk("synced", {31'h0, synced}, 32'h1);
		sw = '{16'hAA99, 16'h5566, 16'h2901, 16'h2000, 16'h2000};
		for (i = 0; i < 5; i++)
			drain(1'b0, sw[i]);
		$display("test status read done");

		wq.delete();
		rb_data <= 32'h8000_0003;
		access(jcr_pkg::OP_READ, 16'h0000);
		chk("scan_len", 32'(wq.size()), 32'(25 + 32));
		chk_scan(6'h04, 32, 80'h0, 0);
		chk("read", rsp_data, 32'h8000_0003);
		chk("no_push", {31'h0, pkt_valid}, 32'h0);
		$display("test readback done");

		o0 = ovr_n;
		for (i = 0; i < 17; i++) begin
			if (i == 16)
				chk("ovr_early", 32'(ovr_n - o0), 32'h0);
			access(jcr_pkg::OP_WRITE, 16'h1000 + 16'(i));
		end
		chk("overrun", {31'h0, ovr_n > o0}, 32'h1);
		for (i = 0; i < 16; i++)
			drain(1'b0, 16'h1000 + 16'(i));
		chk("fifo_empty", {31'h0, pkt_valid}, 32'h0);
		$display("test fifo fill done");

		// Halves swapped and a trailing partial word
		bb_scan(6'h05, 40, {40'h0, 16'h5566, 16'hAA99, 8'hFF});
		chk("synced2", {31'h0, synced2}, 32'h0);
		drain(1'b1, 16'h5566);
		drain(1'b1, 16'hAA99);
		chk("partial", {31'h0, pkt2_valid}, 32'h0);
		bb_scan(6'h05, 32, {48'h0, 16'hAA99, 16'h5566});
		chk("synced2", {31'h0, synced2}, 32'h1);
		$display("test host fault done");
		summarize();
	end
endmodule
`default_nettype wire
